// File: core/uart_abr_pkg.sv
// constants and types for the baud generator with auto-baud detection
package uart_abr_pkg;

  // ----------------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RX_DATA = 8'h0C;
  localparam logic [7:0] OFS_TX_DATA = 8'h10;

  // values after reset
  localparam logic [15:0] BAUD_DIVISOR_RST = 16'h0010;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // control field positions
  localparam int CTL_PE = 0;
  localparam int CTL_OVERSAMPLE_BY_EIGHT = 1;
  localparam int CTL_STOP2 = 2;
  localparam int CTL_SPECIAL = 3;
  localparam int CTL_AUTOBAUD_PATTERN_SEL = 4;
  localparam int CTL_AUTOBAUD_ENABLE = 6;
  localparam int CTL_MSBF = 7;

  // status field positions
  localparam int ST_RX_NOT_EMPTY_FLAG = 0;
  localparam int ST_FE = 1;
  localparam int ST_AUTOBAUD_DONE_FLAG = 2;
  localparam int ST_AUTOBAUD_ERROR_FLAG = 3;
  localparam int ST_TXBUSY = 4;

  // oversampling: samples per bit, first of the three voting samples
  localparam logic [4:0] SMP_X16 = 5'h10;
  localparam logic [4:0] SMP_X8 = 5'h08;
  localparam logic [4:0] VOTE_X16 = 5'h07;
  localparam logic [4:0] VOTE_X8 = 5'h03;
  localparam logic [16:0] ACC_STEP = 17'h00010;

  // auto-baud bit length limits in clocks, and pattern modes
  localparam logic [19:0] ABR_MIN_X16 = 20'h00010;
  localparam logic [19:0] ABR_MIN_X8 = 20'h00008;
  localparam logic [1:0] ABR_START_BIT = 2'h0;
  localparam logic [1:0] ABR_TWO_BITS = 2'h1;
  localparam logic [1:0] ABR_SEVEN_F = 2'h2;
  localparam logic [1:0] ABR_FIVE_FIVE = 2'h3;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
  } rx_state_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8
  } tx_state_t;
  typedef enum logic [3:0] {
    AB_IDLE = 4'h1, AB_ARMED = 4'h2, AB_RUN = 4'h4, AB_END = 4'h8
  } ab_state_t;

endpackage : uart_abr_pkg

// File: core/uart_baud_gen_autobaud.sv
// baud generator, receiver/transmitter timing and auto-baud detection
`timescale 1ns/1ps
module uart_baud_gen_autobaud
  import uart_abr_pkg::*;
#(
  parameter int ABR_MAX_CLKS = 65536
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic rx_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic tx_out,
  output logic rx_not_empty_out
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : bit_rev

  function automatic logic vote3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : vote3

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] div_r;
  logic [7:0] ctl_r;
  logic rx_not_empty_flag_r, fe_r, autobaud_done_flag_r, autobaud_error_flag_r;
  logic [7:0] rx_data_r;
  rx_state_t rx_st_r;
  tx_state_t tx_st_r;
  ab_state_t ab_st_r;
  logic [4:0] rx_smp_r, tx_smp_r;
  logic [2:0] rx_bit_r, tx_bit_r;
  logic [2:0] vote_r;
  logic [7:0] rx_sh_r, tx_sh_r;
  logic tx_stop2_r, rx_prev_r, rx_done_r;
  logic [19:0] ab_cnt_r;
  logic [2:0] ab_falls_r;
  logic ab_rise_r, ab_br0_r;
  logic [1:0] tick;
  logic [1:0] restart;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire logic bus_req = wb_cyc_in & wb_stb_in;
  wire logic wr_fire = bus_req & wb_ack_out & wb_we_in;
  wire logic rd_fire = bus_req & wb_ack_out & ~wb_we_in;
  wire logic sel_div = wb_adr_in == OFS_BAUD_DIVISOR;
  wire logic sel_ctl = wb_adr_in == OFS_CONTROL;
  wire logic sel_st = wb_adr_in == OFS_STATUS;
  wire logic sel_rxd = wb_adr_in == OFS_RX_DATA;
  wire logic sel_txd = wb_adr_in == OFS_TX_DATA;
  wire logic wr_div = wr_fire & sel_div & (|wb_sel_in[1:0]);
  wire logic wr_st = wr_fire & sel_st & wb_sel_in[0];
  // clearing the done flag (write 0) rearms detection
  wire logic autobaud_done_flag_clr = wr_st & ~wb_dat_in[ST_AUTOBAUD_DONE_FLAG];
  wire logic fe_clr = wr_st & wb_dat_in[ST_FE];
  wire logic rx_not_empty_flag_clr = rd_fire & sel_rxd;
  wire logic pe = ctl_r[CTL_PE];
  wire logic msbf = ctl_r[CTL_MSBF];
  wire logic [1:0] ab_mode = ctl_r[CTL_AUTOBAUD_PATTERN_SEL +: 2];
  wire logic [31:0] status_w = {27'h0, tx_st_r != TX_IDLE, autobaud_error_flag_r, autobaud_done_flag_r,
                                fe_r, rx_not_empty_flag_r};
  wire logic [31:0] rd_val = sel_div ? {16'h0, div_r} :
                             sel_ctl ? {24'h0, ctl_r} :
                             sel_st ? status_w :
                             sel_rxd ? {24'h0, rx_data_r} : 32'h0;

  // ----------------------------------------------------------------------
  // oversampling and effective divisor
  // ----------------------------------------------------------------------
  // special modes force sixteen-times oversampling
  // special modes never run at eight
  wire logic oversample_by_eight = ctl_r[CTL_OVERSAMPLE_BY_EIGHT] & ~ctl_r[CTL_SPECIAL];
  wire logic [4:0] n_smp = oversample_by_eight ? SMP_X8 : SMP_X16;
  wire logic [4:0] n_last = n_smp - 5'h01;
  wire logic [4:0] vote_a = oversample_by_eight ? VOTE_X8 : VOTE_X16;
  // register nibble holds divisor bits 3:1, bit 3 ignored
  wire logic [15:0] eff_div = oversample_by_eight ? {div_r[15:4], div_r[2:0], 1'b0} :
                              div_r;

  // ----------------------------------------------------------------------
  // sample tick generators, 0 = transmit, 1 = receive
  // ----------------------------------------------------------------------
  // both generators run off the one divisor register
  // tick rate 16*clk/div: bit rate clk/div or 2*clk/div at eight
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_acc
      logic [16:0] acc_r;
      logic t_r;
      wire logic [16:0] acc_sum = acc_r + ACC_STEP;
      wire logic hit = acc_sum >= {1'b0, eff_div};
      // restart edge counts as the first step, else bit one is a clock longer
      wire logic hit0 = ACC_STEP >= {1'b0, eff_div};
      // fractional accumulator keeps the fraction without a divider
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          acc_r <= 17'h00000;
          t_r <= 1'b0;
        end else if (restart[g]) begin
          acc_r <= hit0 ? ACC_STEP - {1'b0, eff_div} : ACC_STEP;
          t_r <= hit0;
        end else begin
          acc_r <= hit ? acc_sum - {1'b0, eff_div} : acc_sum;
          t_r <= hit;
        end
      end
      assign tick[g] = t_r;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // receive line edges and auto-baud measurement decode
  // ----------------------------------------------------------------------
  wire logic fall = rx_prev_r & ~rx_in;
  wire logic rise = ~rx_prev_r & rx_in;
  wire logic ab_run = ab_st_r == AB_RUN;
  wire logic ab_act = ab_run | (ab_st_r == AB_END);
  // mode 0: start bit, fall to rise
  // first update after the start bit
  wire logic upd_s = ab_run & rise & ~ab_rise_r & (ab_mode != ABR_TWO_BITS);
  // mode 1: start plus bit 0, fall to fall
  wire logic upd_b = ab_run & fall & (ab_mode == ABR_TWO_BITS) &
                     (ab_falls_r == 3'h0);
  // mode 3 second update after bit 0
  wire logic upd_0 = ab_run & fall & (ab_mode == ABR_FIVE_FIVE) &
                     (ab_falls_r == 3'h0);
  // last update at the fall opening bit 7
  wire logic upd_6 = ab_run & fall &
                     (((ab_mode == ABR_SEVEN_F) & (ab_falls_r == 3'h0)) |
                      ((ab_mode == ABR_FIVE_FIVE) & (ab_falls_r == 3'h3)));
  wire logic upd = upd_s | upd_b | upd_0 | upd_6;
  wire logic upd_last = upd_6 | upd_b |
                        (upd_s & (ab_mode == ABR_START_BIT));
  wire logic [19:0] ab_t = upd_6 ? {3'h0, ab_cnt_r[19:3]} :
                           (upd_b | upd_0) ? {1'b0, ab_cnt_r[19:1]} :
                           ab_cnt_r;
  wire logic [2:0] sync_idx = upd_6 ? 3'h7 : (upd_b | upd_0) ? 3'h1 : 3'h0;
  // measured bit must lie within the clock range
  wire logic [19:0] ab_min = oversample_by_eight ? ABR_MIN_X8 : ABR_MIN_X16;
  wire logic range_bad = (ab_t < ab_min) | (ab_t > 20'(ABR_MAX_CLKS));
  wire logic ab_timeout = ab_run & (ab_cnt_r > 20'(ABR_MAX_CLKS));
  wire logic [20:0] d_full = oversample_by_eight ? {ab_t, 1'b0} : {1'b0, ab_t};
  wire logic [15:0] d_sat = (d_full > 21'h00FFFF) ? 16'hFFFF : d_full[15:0];
  // measured divisor stored in the layout of the mode
  wire logic [15:0] d_new = oversample_by_eight ? {d_sat[15:4], 1'b0, d_sat[3:1]} : d_sat;
  // edge inside the middle half of a bit at the bit-0 rate
  wire logic [4:0] q1 = {2'h0, n_smp[4:2]};
  wire logic sync_bad = ab_act & ab_br0_r & (rise | fall) & ~upd &
                        (rx_st_r == RX_DATA) & (rx_smp_r >= q1) &
                        (rx_smp_r < n_smp - q1);
  wire logic rx_end = tick[1] & (rx_smp_r == n_last);
  wire logic maj = vote3(vote_r);
  // a start bit that does not hold low counts as noise
  wire logic ab_abort = ab_act & (rx_st_r == RX_START) & rx_end & maj;
  wire logic ab_err = ab_act & ((upd & range_bad) | sync_bad | ab_timeout |
                                ab_abort);
  wire logic resync = upd & pe;
  wire logic rx_go = pe & (rx_st_r == RX_IDLE) & fall;
  wire logic tx_go = wr_fire & sel_txd & wb_sel_in[0] & pe &
                     (tx_st_r == TX_IDLE);
  wire logic tx_end = tick[0] & (tx_smp_r == n_last);

  // a bus divisor write restarts both baud counters, a measured update only the receive counter
  assign restart[0] = wr_div | tx_go;
  assign restart[1] = wr_div | rx_go | resync;

  // ----------------------------------------------------------------------
  // wishbone slave: one wait state, unmapped reads give zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= bus_req & ~wb_ack_out;
      wb_dat_out <= (bus_req & ~wb_ack_out & ~wb_we_in) ? rd_val : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // divisor and control registers
  // ----------------------------------------------------------------------
  // measured divisor written back by hardware
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_r <= BAUD_DIVISOR_RST;
    end else if (upd & ~range_bad) begin
      div_r <= d_new;
    end else if (wr_div) begin
      div_r[7:0] <= wb_sel_in[0] ? wb_dat_in[7:0] : div_r[7:0];
      div_r[15:8] <= wb_sel_in[1] ? wb_dat_in[15:8] : div_r[15:8];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_r <= CONTROL_RST;
    end else if (wr_fire & sel_ctl & wb_sel_in[0]) begin
      ctl_r <= wb_dat_in[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // status flags: hardware set wins over software clear
  // ----------------------------------------------------------------------
  // the data-ready flag also closes an auto-baud run
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_not_empty_flag_r <= 1'b0;
      fe_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else begin
      rx_not_empty_flag_r <= rx_done_r | (rx_not_empty_flag_r & ~rx_not_empty_flag_clr);
      fe_r <= (rx_done_r & ~maj) | (fe_r & ~fe_clr);
      if (rx_done_r) begin
        rx_data_r <= msbf ? bit_rev(rx_sh_r) : rx_sh_r;
      end
    end
  end

  // error flag sticky, cleared with the rearm
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      autobaud_done_flag_r <= 1'b0;
      autobaud_error_flag_r <= 1'b0;
    end else begin
      autobaud_done_flag_r <= ((ab_st_r == AB_END) & rx_done_r) | ab_abort |
                (autobaud_done_flag_r & ~autobaud_done_flag_clr);
      autobaud_error_flag_r <= ab_err | (autobaud_error_flag_r & ~autobaud_done_flag_clr);
    end
  end

  // ----------------------------------------------------------------------
  // auto-baud sequencer
  // ----------------------------------------------------------------------
  // enable arms and waits for the first falling edge
  // losing the enable disarms only while armed; a run already under way carries on
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ab_st_r <= AB_IDLE;
    end else if (!pe) begin
      ab_st_r <= AB_IDLE;
    end else begin
      case (ab_st_r)
        AB_IDLE: begin
          if (ctl_r[CTL_AUTOBAUD_ENABLE] & ~autobaud_done_flag_r) ab_st_r <= AB_ARMED;
        end
        AB_ARMED: begin
          if (!ctl_r[CTL_AUTOBAUD_ENABLE]) ab_st_r <= AB_IDLE;
          else if (rx_go) ab_st_r <= AB_RUN;
        end
        AB_RUN: begin
          if (ab_abort) ab_st_r <= AB_IDLE;
          else if ((upd & upd_last) | ab_timeout) ab_st_r <= AB_END;
        end
        AB_END: begin
          if (rx_done_r | ab_abort) ab_st_r <= AB_IDLE;
        end
        default: ab_st_r <= AB_IDLE;
      endcase
    end
  end

  // counter runs from the start fall, edges counted per mode
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ab_cnt_r <= 20'h00000;
      ab_falls_r <= 3'h0;
      ab_rise_r <= 1'b0;
      ab_br0_r <= 1'b0;
    end else if (ab_st_r == AB_ARMED) begin
      ab_cnt_r <= 20'h00001; // the start-fall edge is the first clock
      ab_falls_r <= 3'h0;
      ab_rise_r <= 1'b0;
      ab_br0_r <= 1'b0;
    end else if (ab_run) begin
      ab_cnt_r <= (&ab_cnt_r) ? ab_cnt_r : ab_cnt_r + 20'h00001;
      ab_falls_r <= fall ? ab_falls_r + 3'h1 : ab_falls_r;
      ab_rise_r <= ab_rise_r | rise;
      // later edges are judged at the bit-0 rate
      ab_br0_r <= ab_br0_r | upd_0;
    end
  end

  // ----------------------------------------------------------------------
  // receiver sample counter and three-sample vote
  // ----------------------------------------------------------------------
  wire logic vote_hit = (rx_smp_r >= vote_a) & (rx_smp_r <= vote_a + 5'h02);
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_prev_r <= 1'b1;
      rx_smp_r <= 5'h00;
      vote_r <= 3'h7;
    end else begin
      rx_prev_r <= rx_in;
      if (rx_go | resync) begin
        rx_smp_r <= 5'h00;
      end else if (tick[1] & (rx_st_r != RX_IDLE)) begin
        rx_smp_r <= rx_end ? 5'h00 : rx_smp_r + 5'h01;
        // each bit sampled on 8th, 9th and 10th oversamples, 4th to 6th at eight
        if (vote_hit) vote_r <= {vote_r[1:0], rx_in};
      end
    end
  end

  // ----------------------------------------------------------------------
  // receiver framing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_st_r <= RX_IDLE;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (!pe) begin
        rx_st_r <= RX_IDLE;
      end else if (resync) begin
        rx_st_r <= RX_DATA;
        rx_bit_r <= sync_idx;
        if (sync_idx == 3'h1) rx_sh_r[0] <= 1'b1;
        // a bit ending on the measured edge is still kept
        if ((rx_st_r == RX_DATA) & rx_end) rx_sh_r[rx_bit_r] <= maj;
      end else begin
        case (rx_st_r)
          RX_IDLE: begin
            if (fall) rx_st_r <= RX_START;
          end
          RX_START: begin
            if (rx_end) begin
              rx_st_r <= maj ? RX_IDLE : RX_DATA;
              rx_bit_r <= 3'h0;
            end
          end
          RX_DATA: begin
            if (rx_end) begin
              rx_sh_r[rx_bit_r] <= maj;
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == 3'h7) rx_st_r <= RX_STOP;
            end
          end
          RX_STOP: begin
            // second stop never checked, looks like idle
            // ready raised at the end of the first stop
            if (rx_end) begin
              rx_st_r <= RX_IDLE;
              rx_done_r <= 1'b1;
            end
          end
          default: rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter, shares the rate of the receiver
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_st_r <= TX_IDLE;
      tx_smp_r <= 5'h00;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_stop2_r <= 1'b0;
      tx_out <= 1'b1;
    end else if (!pe) begin
      tx_st_r <= TX_IDLE;
      tx_out <= 1'b1;
    end else begin
      if (tick[0] & (tx_st_r != TX_IDLE)) begin
        tx_smp_r <= tx_end ? 5'h00 : tx_smp_r + 5'h01;
      end
      case (tx_st_r)
        TX_IDLE: begin
          tx_out <= 1'b1;
          if (tx_go) begin
            // bit order fixed at load, so the shifter is always lsb first
            tx_sh_r <= msbf ? bit_rev(wb_dat_in[7:0]) : wb_dat_in[7:0];
            tx_stop2_r <= ctl_r[CTL_STOP2];
            tx_smp_r <= 5'h00;
            tx_st_r <= TX_START;
            tx_out <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_end) begin
            tx_st_r <= TX_DATA;
            tx_bit_r <= 3'h0;
            tx_out <= tx_sh_r[0];
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            tx_bit_r <= tx_bit_r + 3'h1;
            tx_out <= (tx_bit_r == 3'h7) ? 1'b1 : tx_sh_r[tx_bit_r + 3'h1];
            if (tx_bit_r == 3'h7) tx_st_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_end) begin
            tx_stop2_r <= 1'b0;
            if (!tx_stop2_r) tx_st_r <= TX_IDLE;
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // data-ready level drives the interrupt line
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_not_empty_out <= 1'b0;
    end else begin
      rx_not_empty_out <= rx_done_r | (rx_not_empty_flag_r & ~rx_not_empty_flag_clr);
    end
  end

endmodule : uart_baud_gen_autobaud

// File: testbench/test_uart_baud_gen_autobaud.sv
// self-checking bench for the baud generator with auto-baud detection
`timescale 1ns/1ps
module test_uart_baud_gen_autobaud;
  import uart_abr_pkg::*;
  // --------
  // stimulus state and hookup
  // --------
  logic clk_sys_in = 1'b0, rst_b_in = 1'b0, cyc = 1'b0, we = 1'b0;
  logic go = 1'b0, bad = 1'b0;
  logic [7:0] adr = 8'h00, tx_byte = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [15:0] bclk = 16'h0040, lfsr = 16'h7477;
  logic [7:0] pat [4] = '{8'h01, 8'h01, 8'h7F, 8'h55};
  logic [7:0] ctl [3] = '{8'h01, 8'h03, 8'h0B};
  logic [31:0] exp_q [$], msk_q [$];
  int miscompares = 0, checks_done = 0;
  wire ack, tx, rx_not_empty_flag, rx, busy, stop2;
  wire [31:0] dout;
  // 40 MHz clock
  always #12.5 clk_sys_in = ~clk_sys_in;
  uart_baud_gen_autobaud #(.ABR_MAX_CLKS(2000)) i_uart_baud_gen_autobaud (
    .clk_sys_in, .rst_b_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .rx_in(rx),
    .wb_ack_out(ack), .wb_dat_out(dout), .tx_out(tx),
    .rx_not_empty_out(rx_not_empty_flag));
  uart_remote_tx i_uart_remote_tx (.clk_in(clk_sys_in), .go_in(go),
    .byte_in(tx_byte), .bit_clks_in(bclk), .stop_bad_in(bad),
    .line_out(rx), .busy_out(busy), .stop2_out(stop2));
  // shift register source of random bytes
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; a read notes its expectation first
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] m);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) miscompares++;
    @(posedge clk_sys_in);
    cyc <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wb
  // length of the first low run on tx, bit 0 being sent as 1
  task automatic tx_low(input int exp);
    int n = 0;
    repeat (3000) begin
      @(posedge clk_sys_in);
      if (tx === 1'b0) n++;
      else if (n > 0) break;
    end
    check(32'(n), 32'(exp));
  endtask : tx_low
  task automatic send();
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
  endtask : send
  // bounded wait: 0 data ready, 1 second stop, 2 partner idle
  task automatic wait_for(input int what);
    repeat (4000) begin
      @(posedge clk_sys_in);
      if (what == 0 ? rx_not_empty_flag === 1'b1 : what == 1 ? stop2 : !busy) break;
    end
  endtask : wait_for
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  // compare each read answer with the oldest note
  always @(posedge clk_sys_in) begin
    if (ack === 1'b1 && !we && exp_q.size() > 0)
      check(dout & msk_q.pop_front(), exp_q.pop_front());
  end
  // watchdog, far beyond the expected run
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end
  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    wb(1'b0, OFS_BAUD_DIVISOR, 32'h10, 32'hFFFF);
    wb(1'b0, OFS_CONTROL, 32'h0, 32'hFF);
    wb(1'b1, 8'h20, 32'hFFFF, 32'h0);
    wb(1'b0, 8'h20, 32'h0, 32'hFFFFFFFF);
    $display("reset test done");
    wb(1'b1, OFS_BAUD_DIVISOR, 32'h40, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, OFS_CONTROL, {24'h0, ctl[i]}, 32'h0);
      lfsr = next_rand(lfsr);
      fork
        wb(1'b1, OFS_TX_DATA, {24'h0, lfsr[7:1], 1'b1}, 32'h0);
        tx_low(i == 1 ? 32 : 64);
      join
      repeat (700) @(posedge clk_sys_in);
    end
    $display("rate test done");
    wb(1'b1, OFS_CONTROL, 32'h5, 32'h0);
    for (int i = 0; i < 2; i++) begin
      lfsr = next_rand(lfsr);
      tx_byte <= lfsr[7:0];
      bad <= i[0];
      send();
      wait_for(1);
      repeat (32) @(posedge clk_sys_in);
      check({31'h0, rx_not_empty_flag}, 32'h1);
      wb(1'b0, OFS_STATUS, {30'h0, i[0], 1'b1}, 32'h3);
      wb(1'b0, OFS_RX_DATA, {24'h0, lfsr[7:0]}, 32'hFF);
      wb(1'b1, OFS_STATUS, 32'h2, 32'h0);
      wait_for(2);
    end
    $display("stop bit test done");
    bad <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      bclk <= 16'(80 + 16 * m);
      tx_byte <= pat[m];
      // mode chosen before detection is enabled
      // peripheral enable stays set throughout detection
      wb(1'b1, OFS_CONTROL, {26'h0, m[1:0], 4'h1}, 32'h0);
      wb(1'b1, OFS_CONTROL, {26'h1, m[1:0], 4'h1}, 32'h0);
      send();
      wait_for(0);
      wb(1'b0, OFS_STATUS, 32'h5, 32'hD);
      wb(1'b0, OFS_BAUD_DIVISOR, 32'(80 + 16 * m), 32'hFFFF);
      wb(1'b0, OFS_RX_DATA, {24'h0, pat[m]}, 32'hFF);
      wb(1'b1, OFS_STATUS, 32'h0, 32'h0);
      wb(1'b0, OFS_STATUS, 32'h0, 32'hC);
      wait_for(2);
    end
    wb(1'b1, OFS_CONTROL, 32'h41, 32'h0);
    bclk <= 16'd10;
    tx_byte <= 8'h01;
    send();
    wait_for(2);
    repeat (2000) @(posedge clk_sys_in);
    wb(1'b0, OFS_STATUS, 32'hC, 32'hC);
    wb(1'b0, OFS_BAUD_DIVISOR, 32'h80, 32'hFFFF);
    $display("auto-baud tests done");
    give_verdict();
  end
endmodule : test_uart_baud_gen_autobaud

// File: testbench/uart_abr_monitor.sv
// checker of bus answers and serial line timing at the block ports
`timescale 1ns/1ps
module uart_abr_monitor
  import uart_abr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic tx_out,
  input wire logic rx_not_empty_out
);
  // --------
  // properties
  // --------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  // qualified bus phases
  wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire rd_rx = wb_ack_out && !wb_we_in && wb_adr_in == OFS_RX_DATA;
  wire rd_st = wb_ack_out && !wb_we_in && wb_adr_in == OFS_STATUS;
  a_ack_follows: assert property (req |=> wb_ack_out)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_out |-> $past(req))
    else $error("ack without request");
  a_dat_quiet: assert property (
    !wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  a_rx_not_empty_flag_clear: assert property (
    $fell(rx_not_empty_out) |-> $past(rd_rx))
    else $error("data ready dropped without read");
  a_rx_not_empty_flag_mirror: assert property (
    rd_st |-> wb_dat_out[ST_RX_NOT_EMPTY_FLAG] == $past(rx_not_empty_out))
    else $error("status and data ready differ");
  // a bit never lasts under eight clocks, divisor being at least 16
  a_tx_low_min: assert property ($fell(tx_out) |-> !tx_out [*8])
    else $error("short low bit on tx");
  a_tx_high_min: assert property ($rose(tx_out) |-> tx_out [*8])
    else $error("short high bit on tx");
endmodule : uart_abr_monitor

bind uart_baud_gen_autobaud uart_abr_monitor i_uart_abr_monitor (
  .clk_sys_in, .rst_b_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_ack_out, .wb_dat_out, .tx_out, .rx_not_empty_out);

// File: testbench/uart_remote_tx.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module uart_remote_tx (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [7:0] byte_in,
  input wire logic [15:0] bit_clks_in,
  input wire logic stop_bad_in,
  output logic line_out,
  output logic busy_out,
  output logic stop2_out
);
  // --------
  // frame sequencer
  // --------
  wire [10:0] frame = {1'b1, !stop_bad_in, byte_in, 1'b0};
  // line idles high, as a pulled-up link does
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
    stop2_out = 1'b0;
  end
  // start, data lsb first, two stops; bit length is any clock count
  always @(posedge clk_in) begin
    if (go_in) begin
      busy_out <= 1'b1;
      for (int i = 0; i < 11; i++) begin
        line_out <= frame[i];
        stop2_out <= (i == 10);
        repeat (bit_clks_in) @(posedge clk_in);
      end
      line_out <= 1'b1;
      busy_out <= 1'b0;
      stop2_out <= 1'b0;
    end
  end
endmodule : uart_remote_tx
